//--- hdl/spi_master_slave_port.v
// serial peripheral port: registers, master clock divider, shift engine

`include "serial_port_defs.vh"

// How it works
// - interrupt request when enable bit, complete flag and global enable are all one.
// - no serial activity unless the port enable bit is one.
// - bit order one shifts lsb first, zero shifts msb first.
// - master select picks mode; low slave select, when it is an input, in master mode clears it, sets flag.
// - polarity one idles clock high, zero idles it low.
// - phase zero samples leading edge; phase one samples trailing edge.
// - master clock is system clock over 4/16/64/128, or 2/8/32/64 doubled.
// - rate select bits do nothing in slave mode.
// - complete flag sets at each byte end and on master mode fault.
// - complete flag clears when the processor takes the interrupt vector.
// - status read with flag set then data access clears the complete flag.
// - data write during a transfer sets the collision flag.
// - status read with collision set then data access clears both flags.
// - double speed doubles master clock; shortest period two system clocks.
// - data write when enabled and not busy loads shift register; in master mode it starts transmission.
// - data read returns the receive buffer, not the shift register.
// - slave select high in slave mode resets shift logic, drops partial bits.
// - receive is double buffered; unread byte is overwritten by the next.
module spi_master_slave_port
(
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire       clk_enable,
  input  wire [5:0] reg_addr,
  input  wire       reg_write,
  input  wire       reg_read,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       global_irq_enable,
  input  wire       irq_vector_taken,
  output wire       transfer_irq,
  input  wire       sck_in,
  output reg        sck_out,
  output wire       sck_oe_n,
  input  wire       mosi_in,
  output reg        mosi_out,
  output wire       mosi_oe_n,
  input  wire       miso_in,
  output reg        miso_out,
  output wire       miso_oe_n,
  input  wire       ss_n_in,
  input  wire       ss_is_input
);

  reg  [7:0] control;
  reg        complete_flag;
  reg        collision_flag;
  reg        double_speed;
  reg  [7:0] shifter;
  reg  [7:0] rx_buffer;
  reg  [3:0] bit_count;
  reg        busy;
  reg        in_second_half;
  reg  [6:0] div_count;
  reg        sampled_bit;
  reg        status_armed;
  reg  [2:0] sck_sync;
  reg  [2:0] ss_sync;
  reg  [2:0] mosi_sync;
  reg  [2:0] miso_sync;
  reg        sck_state;
  reg        ss_state;
  reg        mosi_state;
  reg        miso_state;
  reg        next_complete;
  reg        next_collision;
  reg  [6:0] half_period;
  reg        next_out_bit;

  // register offsets are compared in several places
  function reg_hit;
    input [5:0] addr;
    input [5:0] offset;
    begin
      reg_hit = addr == offset;
    end
  endfunction

  wire enabled   = control[`BIT_PORT_ENABLE];
  wire master    = control[`BIT_MASTER];
  wire lsb_first = control[`BIT_ORDER];
  wire polarity  = control[`BIT_POLARITY];
  wire phase     = control[`BIT_PHASE];

  wire wr_buffer  = reg_write && reg_hit(reg_addr, `BUFFER_OFFSET);
  wire rd_buffer  = reg_read && reg_hit(reg_addr, `BUFFER_OFFSET);
  wire rd_flags   = reg_read && reg_hit(reg_addr, `FLAGS_OFFSET);
  wire wr_control = reg_write && reg_hit(reg_addr, `CONTROL_OFFSET);
  wire wr_flags   = reg_write && reg_hit(reg_addr, `FLAGS_OFFSET);

  // serial line inputs settle only when the second and third stage agree
  wire sck_now  = (sck_sync[2] == sck_sync[1]) ? sck_sync[1] : sck_state;
  wire ss_now   = (ss_sync[2] == ss_sync[1]) ? ss_sync[1] : ss_state;
  wire mosi_now = (mosi_sync[2] == mosi_sync[1]) ? mosi_sync[1] : mosi_state;
  wire miso_now = (miso_sync[2] == miso_sync[1]) ? miso_sync[1] : miso_state;

  wire mode_fault  = enabled && master && ss_is_input && !ss_now;
  wire slave_sel   = enabled && !master && !ss_now;
  wire slave_drop  = enabled && !master && ss_now;
  // slave edges come from the filtered pin; relative to polarity, rising means leading
  wire slave_lead  = slave_sel && (sck_now ^ polarity) && !(sck_state ^ polarity);
  wire slave_trail = slave_sel && !(sck_now ^ polarity) && (sck_state ^ polarity);

  // master half-period ticks from the divider; rate bits ignored when slave
  wire master_tick = enabled && master && busy && div_count == half_period;
  wire lead_edge   = master ? (master_tick && !in_second_half) : slave_lead;
  wire trail_edge  = master ? (master_tick && in_second_half) : slave_trail;
  wire serial_in   = master ? miso_now : mosi_now;
  wire sample_edge = phase ? trail_edge : lead_edge;
  wire setup_edge  = phase ? lead_edge : trail_edge;
  wire last_bit    = bit_count == `BITS_PER_BYTE - 4'h1;
  wire byte_done   = trail_edge && last_bit;

  function out_bit;
    input [7:0] data;
    input       lsb;
    begin
      out_bit = lsb ? data[0] : data[7];
    end
  endfunction

  function [7:0] shift_in;
    input [7:0] data;
    input       lsb;
    input       bit_in;
    begin
      shift_in = lsb ? {bit_in, data[7:1]} : {data[6:0], bit_in};
    end
  endfunction

  // byte after the trailing edge shift; phase one takes the live line
  wire [7:0] shifted = shift_in(shifter, lsb_first, phase ? serial_in : sampled_bit);

  // bit put on the data line at a setup edge
  always @*
  begin
    if (phase)
      next_out_bit = out_bit(shifter, lsb_first);
    else
      next_out_bit = out_bit(shift_in(shifter, lsb_first, sampled_bit), lsb_first);
  end

  // half period in system clocks minus one
  always @*
  begin
    case ({double_speed, control[`BIT_RATE_HIGH:`BIT_RATE_LOW]})
      3'b000:  half_period = `HALF_DIV_4;
      3'b001:  half_period = `HALF_DIV_16;
      3'b010:  half_period = `HALF_DIV_64;
      3'b011:  half_period = `HALF_DIV_128;
      3'b100:  half_period = `HALF_DIV_2;
      3'b101:  half_period = `HALF_DIV_8;
      3'b110:  half_period = `HALF_DIV_32;
      3'b111:  half_period = `HALF_DIV_64;
      default: half_period = `HALF_DIV_4;
    endcase
  end

  assign transfer_irq = control[`BIT_IRQ_ENABLE] && complete_flag && global_irq_enable;

  assign sck_oe_n  = !(enabled && master);
  assign mosi_oe_n = !(enabled && master);
  assign miso_oe_n = !slave_sel;

  // flags: a set in the same cycle as a clear wins
  always @*
  begin
    next_complete  = complete_flag;
    next_collision = collision_flag;
    if (irq_vector_taken)
      next_complete = 1'b0;
    if (status_armed && (rd_buffer || wr_buffer))
    begin
      next_complete  = 1'b0;
      next_collision = 1'b0;
    end
    if (byte_done || mode_fault)
      next_complete = 1'b1;
    if (wr_buffer && busy)
      next_collision = 1'b1;
  end

  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      control        <= `CONTROL_RESET;
      complete_flag  <= 1'b0;
      collision_flag <= 1'b0;
      double_speed   <= 1'b0;
      shifter        <= `BUFFER_RESET;
      rx_buffer      <= `BUFFER_RESET;
      bit_count      <= 4'h0;
      busy           <= 1'b0;
      in_second_half <= 1'b0;
      div_count      <= 7'h00;
      sampled_bit    <= 1'b0;
      status_armed   <= 1'b0;
      sck_sync       <= 3'b000;
      ss_sync        <= 3'b111;
      mosi_sync      <= 3'b000;
      miso_sync      <= 3'b000;
      sck_state      <= 1'b0;
      ss_state       <= 1'b1;
      mosi_state     <= 1'b0;
      miso_state     <= 1'b0;
      sck_out        <= 1'b0;
      mosi_out       <= 1'b0;
      miso_out       <= 1'b0;
      reg_rdata      <= 8'h00;
    end
    else if (clk_enable)
    begin
      sck_sync   <= {sck_sync[1:0], sck_in};
      ss_sync    <= {ss_sync[1:0], ss_n_in};
      mosi_sync  <= {mosi_sync[1:0], mosi_in};
      miso_sync  <= {miso_sync[1:0], miso_in};
      sck_state  <= sck_now;
      ss_state   <= ss_now;
      mosi_state <= mosi_now;
      miso_state <= miso_now;

      complete_flag  <= next_complete;
      collision_flag <= next_collision;

      // arming survives until the data register is touched
      if (rd_flags)
        status_armed <= complete_flag || collision_flag;
      else if (rd_buffer || wr_buffer)
        status_armed <= 1'b0;

      case (reg_addr)
        `CONTROL_OFFSET: reg_rdata <= control;
        `FLAGS_OFFSET:   reg_rdata <= {complete_flag, collision_flag, 5'h00, double_speed};
        `BUFFER_OFFSET:  reg_rdata <= rx_buffer;
        default:         reg_rdata <= 8'h00;
      endcase

      if (wr_control)
        control <= reg_wdata;
      else if (mode_fault)
        control[`BIT_MASTER] <= 1'b0;
      if (wr_flags)
        double_speed <= reg_wdata[`BIT_DOUBLE_SPEED];

      if (!enabled || slave_drop || mode_fault)
      begin
        // idle or deselected: drop any partial byte, park the clock
        busy           <= 1'b0;
        bit_count      <= 4'h0;
        in_second_half <= 1'b0;
        div_count      <= 7'h00;
        sck_out        <= polarity;
        if (wr_buffer && enabled)
          shifter <= reg_wdata;
      end
      else
      begin
        if (wr_buffer && !busy)
        begin
          shifter   <= reg_wdata;
          busy      <= master;
          bit_count <= 4'h0;
          div_count <= 7'h00;
          if (master)
            mosi_out <= out_bit(reg_wdata, lsb_first);
          else
            miso_out <= out_bit(reg_wdata, lsb_first);
        end
        else
        begin
          if (!master && slave_lead)
            busy <= 1'b1;
          if (master && busy)
          begin
            if (master_tick)
            begin
              div_count      <= 7'h00;
              in_second_half <= !in_second_half;
              sck_out        <= !sck_out;
            end
            else
              div_count <= div_count + 7'h01;
          end
          // an idle master parks too, so a polarity change shows before the next byte
          else
            sck_out <= polarity;
          if (sample_edge)
            sampled_bit <= serial_in;
          // the shift happens on the trailing edge, taking the bit caught at sampling
          if (trail_edge)
          begin
            shifter   <= shifted;
            bit_count <= bit_count + 4'h1;
            if (byte_done)
            begin
              rx_buffer <= shifted;
              busy      <= 1'b0;
              bit_count <= 4'h0;
            end
          end
          // phase one drives the next bit at the leading edge
          if (setup_edge && !byte_done)
          begin
            if (master)
              mosi_out <= next_out_bit;
            else
              miso_out <= next_out_bit;
          end
        end
      end
    end
  end

endmodule

//--- hdl/serial_port_defs.vh
// offsets, field positions, reset values and timing counts of the serial port
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH
`define CONTROL_OFFSET     6'h0d
`define FLAGS_OFFSET       6'h0e
`define BUFFER_OFFSET      6'h0f
`define CONTROL_RESET      8'h00
`define FLAGS_RESET        8'h00
`define BUFFER_RESET       8'h00
`define BIT_IRQ_ENABLE     7
`define BIT_PORT_ENABLE    6
`define BIT_ORDER          5
`define BIT_MASTER         4
`define BIT_POLARITY       3
`define BIT_PHASE          2
`define BIT_RATE_HIGH      1
`define BIT_RATE_LOW       0
`define BIT_COMPLETE       7
`define BIT_COLLISION      6
`define BIT_DOUBLE_SPEED   0
`define BITS_PER_BYTE      4'h8
`define HALF_DIV_4         7'h01
`define HALF_DIV_16        7'h07
`define HALF_DIV_64        7'h1f
`define HALF_DIV_128       7'h3f
`define HALF_DIV_2         7'h00
`define HALF_DIV_8         7'h03
`define HALF_DIV_32        7'h0f
`endif

//--- verification/spi_port_chk.sv
// assertion checker watching the serial port's pins and register strobes
module spi_port_chk
(
  input logic       ref_clk,
  input logic       reset_n,
  input logic [5:0] reg_addr,
  input logic       reg_write,
  input logic       reg_read,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic       global_irq_enable,
  input logic       irq_vector_taken,
  input logic       transfer_irq,
  input logic       sck_out,
  input logic       sck_oe_n,
  input logic       mosi_oe_n,
  input logic       miso_oe_n,
  input logic       ss_n_in,
  input logic       ss_is_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       irq_en, port_en, pol, dbl, run, sck_prev;
  logic [1:0] rate;
  logic [4:0] tog;
  logic [7:0] cnt;
  logic [7:0] half_exp;
  wire        wr_ctl = reg_write && reg_addr == 6'h0d;
  wire        wr_buf = reg_write && reg_addr == 6'h0f;
  // half period in system clocks; double speed halves it
  assign half_exp = (dbl ? 8'h01 : 8'h02) << {rate, 1'b0} >> (rate == 2'h3);
  always @(posedge ref_clk)
  begin
    sck_prev <= sck_out;
    cnt      <= (sck_out != sck_prev) ? 8'h01 : cnt + {7'h00, cnt != 8'hff};
    if (!reset_n)
      {irq_en, port_en, pol, rate, dbl, run, tog} <= '0;
    else
    begin
      if (wr_ctl)
        {irq_en, port_en, pol, rate} <= {reg_wdata[7:6], reg_wdata[3], reg_wdata[1:0]};
      if (reg_write && reg_addr == 6'h0e)
        dbl <= reg_wdata[0];
      // a control write ends edge counting, so an idle level change is never a bit
      if (wr_ctl)
        {run, tog} <= '0;
      else if (wr_buf && port_en && !run)
        {run, tog} <= {1'b1, 5'h00};
      else if (run && sck_out != sck_prev)
        {run, tog} <= {tog != 5'h0f, tog + 5'h01};
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  AST_IRQ_GATE: assert property (
    transfer_irq |-> global_irq_enable && irq_en)
    else $error("interrupt request without its enables");
  AST_VECTOR_CLEAR: assert property (
    irq_vector_taken |=> !transfer_irq)
    else $error("interrupt still requested after vector");
  AST_OFF_PINS: assert property (
    !port_en |-> sck_oe_n && mosi_oe_n && miso_oe_n)
    else $error("pin driven while port disabled");
  AST_OFF_CLOCK: assert property (
    !port_en [*4] |-> $stable(sck_out))
    else $error("serial clock moved while port disabled");
  AST_MODE_FAULT: assert property (
    (ss_is_input && !ss_n_in) [*4] |-> ##[1:6] (sck_oe_n && mosi_oe_n))
    else $error("master kept driving with select pulled low");
  AST_IDLE_LEVEL: assert property (
    wr_ctl && reg_wdata[6] && reg_wdata[4] && !run |-> ##4 sck_out == pol)
    else $error("serial clock idle level wrong");
  AST_FLAG_CLEAR: assert property (
    (reg_read && reg_addr == 6'h0e) ##1 reg_rdata[7] ##1 (reg_read && reg_addr == 6'h0f)
    ##2 (reg_read && reg_addr == 6'h0e) |-> ##1 reg_rdata[7:6] == 2'b00)
    else $error("flags not cleared by status then buffer access");
  AST_HALF_PERIOD: assert property (
    run && $changed(sck_out) && tog != 5'h00 |-> cnt == half_exp)
    else $error("serial clock half period wrong");
  AST_EIGHT_BITS: assert property (
    $changed(sck_out) |-> tog != 5'h10)
    else $error("serial clock edge beyond eight bits");
  CVR_COLLIDE: cover property (wr_buf && run);
  CVR_BYTE: cover property ($fell(run) && tog == 5'h10);
  CVR_IRQ: cover property (transfer_irq);
endmodule

bind spi_master_slave_port spi_port_chk u_chk
(
  .ref_clk, .reset_n, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata,
  .global_irq_enable, .irq_vector_taken, .transfer_irq, .sck_out, .sck_oe_n,
  .mosi_oe_n, .miso_oe_n, .ss_n_in, .ss_is_input
);

//--- verification/spi_peer_model.sv
// behavioural serial slave answering the port while it is master
module spi_peer_model
(
  input  logic       sck,
  input  logic       mosi,
  input  logic       clock_polarity,
  input  logic       clock_phase,
  input  logic       lsb_first,
  input  logic       sel,
  input  logic       load,
  input  logic [7:0] tx_byte,
  output logic       miso,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx;
  logic [3:0] taken;
  wire        out_bit = lsb_first ? tx[0] : tx[7];
  // a released line shows the inverse of its last level, never a stale copy
  assign miso = sel ? out_bit : !out_bit;
  always @(posedge load or posedge sck or negedge sck)
  begin
    if (load)
    begin
      tx = tx_byte;
      taken = 4'h0;
    end
    else if (sck ^ clock_polarity ^ clock_phase)
    begin
      rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
      taken = taken + 4'h1;
    end
    else if (taken != 4'h0)
      tx = lsb_first ? tx >> 1 : tx << 1;
  end
endmodule

//--- verification/tb_spi_master_slave_port.sv
// self-checking bench: register accesses and master transfers against a peer
module tb_spi_master_slave_port;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHECK(what, exp, got) \
    begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
        bad_count++; \
        $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
    end
  logic       ref_clk, reset_n, reg_write, reg_read, global_irq_enable, irq_vector_taken;
  logic       sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_in, miso_out, miso_oe_n;
  logic       transfer_irq, ss_n_in, ss_is_input, peer_sel, peer_load, sck_in, mosi_in;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, peer_tx, peer_rx, rd, cur, sbyte;
  int         bad_count, cmp_count, cyc, i, n;
  // four clock modes, both bit orders; half periods long enough for input sync
  logic [7:0] cfg_ctl [4] = '{8'h51, 8'h7e, 8'h56, 8'h7b};
  logic       cfg_dbl [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  spi_master_slave_port u_dut
  (
    .ref_clk, .reset_n, .clk_enable(1'b1), .reg_addr, .reg_write, .reg_read,
    .reg_wdata, .reg_rdata, .global_irq_enable, .irq_vector_taken, .transfer_irq,
    .sck_in, .sck_out, .sck_oe_n, .mosi_in, .mosi_out, .mosi_oe_n,
    .miso_in, .miso_out, .miso_oe_n, .ss_n_in, .ss_is_input
  );
  spi_peer_model u_peer
  (
    .sck(sck_out), .mosi(mosi_out), .clock_polarity(cur[3]), .clock_phase(cur[2]), .lsb_first(cur[5]),
    .sel(peer_sel), .load(peer_load), .tx_byte(peer_tx), .miso(miso_in), .rx_byte(peer_rx)
  );
  task automatic access(input logic [5:0] a, input logic wr, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_write <= wr;
    reg_read  <= !wr;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    reg_read  <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic wait_flag;
    n = 0;
    rd = 8'h00;
    while (rd[7] !== 1'b1 && n < 400)
    begin
      access(6'h0e, 1'b0, 8'h00);
      n++;
    end
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = !ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      print_verdict;
    end
  end
  initial
  begin
    {reset_n, reg_write, reg_read, global_irq_enable, irq_vector_taken} = '0;
    {ss_is_input, peer_sel, peer_load, reg_addr, reg_wdata, peer_tx, cur} = '0;
    ss_n_in = 1'b1;
    {sck_in, mosi_in} = 2'b00;
    sbyte = 8'h3c;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    access(6'h0d, 1'b0, 8'h00);
    `CHECK("control reset", 8'h00, rd)
    access(6'h0e, 1'b0, 8'h00);
    `CHECK("flags reset", 8'h00, rd)
    access(6'h3f, 1'b0, 8'h00);
    `CHECK("unmapped read", 8'h00, rd)
    access(6'h0d, 1'b1, 8'h11);
    access(6'h0f, 1'b1, 8'ha5);
    repeat (40) @(posedge ref_clk);
    access(6'h0e, 1'b0, 8'h00);
    `CHECK("flags while disabled", 8'h00, rd)
    `CHECK("clock drive while disabled", 1'b1, sck_oe_n)
    for (i = 0; i < 4; i++)
    begin
      cur = cfg_ctl[i];
      access(6'h0d, 1'b1, cfg_ctl[i]);
      access(6'h0e, 1'b1, {7'h00, cfg_dbl[i]});
      peer_tx = 8'hc5 + 8'(i);
      peer_sel = 1'b1;
      peer_load = 1'b1;
      #1 peer_load = 1'b0;
      access(6'h0f, 1'b1, 8'h96 ^ 8'(i));
      access(6'h0f, 1'b1, 8'h00);
      wait_flag;
      `CHECK("flags after byte", {2'b11, 5'h00, cfg_dbl[i]}, rd)
      access(6'h0f, 1'b0, 8'h00);
      `CHECK("received byte", peer_tx, rd)
      access(6'h0e, 1'b0, 8'h00);
      `CHECK("flags after buffer read", {7'h00, cfg_dbl[i]}, rd)
      `CHECK("byte seen by peer", 8'h96 ^ 8'(i), peer_rx)
      peer_sel = 1'b0;
    end
    access(6'h0d, 1'b1, 8'hd1);
    @(posedge ref_clk);
    ss_is_input <= 1'b1;
    ss_n_in <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 `CHECK("irq with global off", 1'b0, transfer_irq)
    @(posedge ref_clk);
    global_irq_enable <= 1'b1;
    @(posedge ref_clk);
    #1 `CHECK("irq after mode fault", 1'b1, transfer_irq)
    access(6'h0d, 1'b0, 8'h00);
    `CHECK("control after mode fault", 8'hc1, rd)
    @(posedge ref_clk);
    irq_vector_taken <= 1'b1;
    ss_n_in <= 1'b1;
    @(posedge ref_clk);
    irq_vector_taken <= 1'b0;
    #1 `CHECK("irq after vector", 1'b0, transfer_irq)
    // now an enabled slave; an external master clocks at an eighth of the system clock
    repeat (6) @(posedge ref_clk);
    ss_n_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    for (i = 7; i >= 0; i--)
    begin
      mosi_in <= sbyte[i];
      repeat (4) @(posedge ref_clk);
      sck_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sck_in <= 1'b0;
    end
    repeat (6) @(posedge ref_clk);
    access(6'h0e, 1'b0, 8'h00);
    `CHECK("flags after slave byte", 8'h81, rd)
    access(6'h0f, 1'b0, 8'h00);
    `CHECK("slave received byte", sbyte, rd)
    access(6'h0e, 1'b0, 8'h00);
    `CHECK("flags after slave read", 8'h01, rd)
    print_verdict;
  end
endmodule
